// [rtl/fci_host.sv]
// Purpose: Host controller that issues command sequences to a parallel NOR flash.
// Assumes: Device pins are sampled synchronously to clk_sys_i.
// Notes: One order at a time; status polling is left to the user.
`timescale 1ns/1ns
`default_nettype none
`include "fci_cfg.svh"
// How it works
// [R1] Enhanced configuration: 0060h then 0004h, register value on address both times.
// [R2] Protection program: 00C0h setup, then offset and data in second write.
// [R3] Device refuses protection writes outside the area and flags an error.
// [R4] Error flags accumulate; only clear-status 0050h clears them.
// [R5] Status pin configuration: 00B8h then value on data.
// [R6] Single 00FFh write returns the device to array read.
// [R7] Single 0070h write selects status read.
// [R8] 0090h selects identifier read, device code at 00001h; 0098h selects query.
// [R9] Word or byte program: 0040h or 0010h, then data to same location.
// [R10] Block erase: 0020h then 00D0h as the very next write.
// [R11] Device accepts only one erase at a time, no queue.
// [R12] Status bit 7 reads 1 when ready, 0 while busy.
// [R13] Output enable toggle refreshes the status byte.
// [R14] Status bit 3 flags low programming supply.
// [R15] Status bit 1 flags a protected target.
// [R16] Status bit 4 flags a failed program.
// [R17] After supply error, programs are refused until status is cleared.
// [R18] Host clears status flags after any error before retry; the controller clears them only on a user clear-status order.
// [R19] Program to a locked protection segment sets bits 4 and 1.
// [R20] Protection lock: program 0xFFFD to the lock word; irreversible.
// [R21] Buffered program: 00E8h at word address, ends with 00D0h confirm.
// [R22] 00B0h suspends; 00D0h resumes.
// [R23] Lock block: 0060h then 0001h; unlock: 0060h then 00D0h.
module fci_host
  import fci_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic req_i,
  input wire logic [3:0] op_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic buf_start_i,
  input wire logic read_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic seq_ready_o,
  output logic err_flag_o,
  output logic supply_block_o,
  output logic [23:0] flash_addr_o,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [15:0] flash_dq_i,
  output logic flash_we_n_o,
  output logic flash_oe_n_o,
  output logic flash_ce_n_o
);
  logic rst_s1, rst_n;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  fci_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  logic second, next_second;
  logic two, next_two;
  logic [23:0] a2, next_a2;
  logic [15:0] d2, next_d2;
  logic [23:0] faddr, next_faddr;
  logic [15:0] fdq, next_fdq;
  logic dq_oe, next_dq_oe, we_n, next_we_n, oe_n, next_oe_n, ce_n, next_ce_n;
  logic busy, next_busy, done, next_done;
  logic [15:0] rdata, next_rdata;
  logic rdy, next_rdy, err, next_err, sblk, next_sblk;
  logic refuse;

  // A program is held back while the device reports a supply fault. see [R17]
  always_comb begin
    refuse = sblk && (op_i == FCI_OP_WORD_PROG || op_i == FCI_OP_BYTE_PROG ||
                      op_i == FCI_OP_OTP_PROG || op_i == FCI_OP_BUF_CONFIRM);
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_second = second;
    next_two = two;
    next_a2 = a2;
    next_d2 = d2;
    next_faddr = faddr;
    next_fdq = fdq;
    next_dq_oe = dq_oe;
    next_we_n = we_n;
    next_oe_n = oe_n;
    next_ce_n = ce_n;
    next_busy = busy;
    next_done = 1'b0;
    next_rdata = rdata;
    next_rdy = rdy;
    next_err = err;
    next_sblk = sblk;
    unique case (state)
      FCI_ST_IDLE: begin
        if (req_i && !refuse) begin
          next_busy = 1'b1;
          next_state = FCI_ST_WRITE;
          next_cnt = 8'(`FCI_STROBE_CYC);
          next_second = 1'b0;
          next_two = 1'b1;
          next_faddr = addr_i;
          next_a2 = addr_i;
          next_d2 = data_i;
          next_ce_n = 1'b0;
          next_we_n = 1'b0;
          next_dq_oe = 1'b1;
          unique case (fci_op_t'(op_i))
            FCI_OP_READ_ARRAY: begin
              next_fdq = `FCI_CMD_READ_ARRAY; // see [R6]
              next_two = 1'b0;
            end
            FCI_OP_READ_STATUS: begin
              next_fdq = `FCI_CMD_READ_STATUS; // see [R7]
              next_two = 1'b0;
            end
            FCI_OP_READ_ID: begin
              next_fdq = `FCI_CMD_READ_ID; // see [R8]
              next_two = 1'b0;
            end
            FCI_OP_QUERY: begin
              next_fdq = `FCI_CMD_QUERY; // see [R8]
              next_two = 1'b0;
            end
            FCI_OP_CLEAR_STATUS: begin
              next_fdq = `FCI_CMD_CLEAR_STATUS; // see [R4] see [R18]
              next_two = 1'b0;
              next_err = 1'b0;
              next_sblk = 1'b0;
            end
            FCI_OP_WORD_PROG: next_fdq = `FCI_CMD_WORD_PROG; // see [R9]
            FCI_OP_BYTE_PROG: next_fdq = `FCI_CMD_BYTE_PROG; // see [R9]
            FCI_OP_ERASE: next_d2 = `FCI_CMD_CONFIRM; // see [R10]
            FCI_OP_BUF_CONFIRM: begin
              next_fdq = buf_start_i ? `FCI_CMD_BUF_PROG : `FCI_CMD_CONFIRM; // see [R21]
              next_two = 1'b0;
            end
            FCI_OP_SUSPEND: begin
              next_fdq = `FCI_CMD_SUSPEND; // see [R22]
              next_two = 1'b0;
            end
            FCI_OP_RESUME: begin
              next_fdq = `FCI_CMD_CONFIRM; // see [R22]
              next_two = 1'b0;
            end
            FCI_OP_LOCK: begin
              next_fdq = `FCI_CMD_CFG_SETUP;
              next_d2 = `FCI_CMD_LOCK_CONFIRM; // see [R23]
            end
            FCI_OP_UNLOCK: begin
              next_fdq = `FCI_CMD_CFG_SETUP;
              next_d2 = `FCI_CMD_CONFIRM; // see [R23]
            end
            FCI_OP_ECR: begin
              next_fdq = `FCI_CMD_CFG_SETUP; // see [R1]
              next_d2 = `FCI_CMD_ECR_CONFIRM;
            end
            FCI_OP_OTP_PROG: next_fdq = `FCI_CMD_OTP_SETUP; // see [R2] see [R20]
            FCI_OP_PIN_CFG: next_fdq = `FCI_CMD_PIN_CFG; // see [R5]
          endcase
          if (fci_op_t'(op_i) == FCI_OP_ERASE) begin
            next_fdq = `FCI_CMD_ERASE_SETUP; // see [R10] see [R11]
          end
        end else if (read_i) begin
          next_busy = 1'b1;
          next_state = FCI_ST_READ;
          next_cnt = 8'(`FCI_STROBE_CYC);
          next_faddr = addr_i;
          next_ce_n = 1'b0;
          next_oe_n = 1'b0; // see [R13]
          next_dq_oe = 1'b0;
        end
      end
      FCI_ST_WRITE: begin
        if (cnt == 8'd1) begin
          next_we_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = 8'(`FCI_GAP_CYC);
          next_state = FCI_ST_GAP;
        end else begin
          next_cnt = cnt - 8'd1;
        end
      end
      FCI_ST_GAP: begin
        if (cnt == 8'd1) begin
          if (two && !second) begin
            next_second = 1'b1;
            next_faddr = a2;
            next_fdq = d2;
            next_we_n = 1'b0;
            next_ce_n = 1'b0;
            next_cnt = 8'(`FCI_STROBE_CYC);
            next_state = FCI_ST_WRITE;
          end else begin
            next_dq_oe = 1'b0;
            next_state = FCI_ST_DONE;
          end
        end else begin
          next_cnt = cnt - 8'd1;
        end
      end
      FCI_ST_READ: begin
        if (cnt == 8'd1) begin
          next_rdata = flash_dq_i;
          next_rdy = flash_dq_i[`FCI_BIT_READY]; // see [R12]
          next_err = err | flash_dq_i[`FCI_BIT_PROG_FAIL] | flash_dq_i[`FCI_BIT_SUPPLY] |
                     flash_dq_i[`FCI_BIT_PROTECT]; // see [R14] see [R15] see [R16] see [R19]
          next_sblk = sblk | flash_dq_i[`FCI_BIT_SUPPLY]; // see [R17]
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          next_state = FCI_ST_DONE;
        end else begin
          next_cnt = cnt - 8'd1;
        end
      end
      FCI_ST_DONE: begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = FCI_ST_IDLE;
      end
      default: next_state = FCI_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= FCI_ST_IDLE;
      cnt <= 8'h00;
      second <= 1'b0;
      two <= 1'b0;
      a2 <= 24'h00_0000;
      d2 <= 16'h0000;
      faddr <= 24'h00_0000;
      fdq <= 16'h0000;
      dq_oe <= 1'b0;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      ce_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
      rdy <= 1'b0;
      err <= 1'b0;
      sblk <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      second <= next_second;
      two <= next_two;
      a2 <= next_a2;
      d2 <= next_d2;
      faddr <= next_faddr;
      fdq <= next_fdq;
      dq_oe <= next_dq_oe;
      we_n <= next_we_n;
      oe_n <= next_oe_n;
      ce_n <= next_ce_n;
      busy <= next_busy;
      done <= next_done;
      rdata <= next_rdata;
      rdy <= next_rdy;
      err <= next_err;
      sblk <= next_sblk;
    end
  end

  assign busy_o = busy;
  assign done_o = done;
  assign rdata_o = rdata;
  assign seq_ready_o = rdy;
  assign err_flag_o = err;
  assign supply_block_o = sblk;
  assign flash_addr_o = faddr;
  assign flash_dq_o = fdq;
  assign flash_dq_oe_o = dq_oe;
  assign flash_we_n_o = we_n;
  assign flash_oe_n_o = oe_n;
  assign flash_ce_n_o = ce_n;

  property p_erase_confirm_next;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state == FCI_ST_GAP && second == 1'b0 && two && fdq == `FCI_CMD_ERASE_SETUP && cnt == 8'd1)
      |=> (!we_n && fdq == `FCI_CMD_CONFIRM);
  endproperty
  a_erase_confirm_next: assert property (p_erase_confirm_next) else $error("Erase confirm not next."); // see [R10]

  property p_supply_refuse;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state == FCI_ST_IDLE && sblk && req_i && op_i == FCI_OP_WORD_PROG) |=> (state == FCI_ST_IDLE);
  endproperty
  a_supply_refuse: assert property (p_supply_refuse) else $error("Program sent under supply fault."); // see [R17]

  property p_clear_flags;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state == FCI_ST_IDLE && req_i && op_i == FCI_OP_CLEAR_STATUS) |=> (!err && !sblk && fdq == `FCI_CMD_CLEAR_STATUS);
  endproperty
  a_clear_flags: assert property (p_clear_flags) else $error("Clear status did not clear flags."); // see [R4]

  property p_err_sticky;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (err && !(state == FCI_ST_IDLE && req_i && op_i == FCI_OP_CLEAR_STATUS)) |=> err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("Error flag lost without clear."); // see [R4]

  property p_ready_capture;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state == FCI_ST_READ && cnt == 8'd1) |=> (rdy == $past(flash_dq_i[`FCI_BIT_READY]));
  endproperty
  a_ready_capture: assert property (p_ready_capture) else $error("Ready bit not captured."); // see [R12]

  property p_read_array_single;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state == FCI_ST_IDLE && req_i && op_i == FCI_OP_READ_ARRAY) |=> (!two && fdq == `FCI_CMD_READ_ARRAY);
  endproperty
  a_read_array_single: assert property (p_read_array_single) else $error("Read array not single write."); // see [R6]

  property p_ecr_addr;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state == FCI_ST_WRITE && second && fdq == `FCI_CMD_ECR_CONFIRM) |-> (faddr == a2);
  endproperty
  a_ecr_addr: assert property (p_ecr_addr) else $error("Configuration value not on address."); // see [R1]

  property p_status_cmd;
    @(posedge clk_sys_i) disable iff (!rst_n)
    (state == FCI_ST_IDLE && req_i && op_i == FCI_OP_READ_STATUS) |=> (!we_n && !ce_n && fdq == `FCI_CMD_READ_STATUS);
  endproperty
  a_status_cmd: assert property (p_status_cmd) else $error("Status read command not driven."); // see [R7]
endmodule
`default_nettype wire

// [rtl/fci_cfg.svh]
// Purpose: Named constants for the flash command host controller.
// Assumes: Word-wide device bus, 250 MHz system clock.
// Notes: Bus cycle lengths are counts of system clock cycles.
`ifndef FCI_CFG_SVH
`define FCI_CFG_SVH
`define FCI_CMD_READ_ARRAY 16'h00FF
`define FCI_CMD_READ_STATUS 16'h0070
`define FCI_CMD_READ_ID 16'h0090
`define FCI_CMD_QUERY 16'h0098
`define FCI_CMD_CLEAR_STATUS 16'h0050
`define FCI_CMD_WORD_PROG 16'h0040
`define FCI_CMD_BYTE_PROG 16'h0010
`define FCI_CMD_ERASE_SETUP 16'h0020
`define FCI_CMD_CONFIRM 16'h00D0
`define FCI_CMD_BUF_PROG 16'h00E8
`define FCI_CMD_SUSPEND 16'h00B0
`define FCI_CMD_CFG_SETUP 16'h0060
`define FCI_CMD_ECR_CONFIRM 16'h0004
`define FCI_CMD_LOCK_CONFIRM 16'h0001
`define FCI_CMD_OTP_SETUP 16'h00C0
`define FCI_CMD_PIN_CFG 16'h00B8
`define FCI_OTP_LOCK_VALUE 16'hFFFD
`define FCI_ID_ADDR 24'h00_0001
`define FCI_BIT_READY 7
`define FCI_BIT_PROG_FAIL 4
`define FCI_BIT_SUPPLY 3
`define FCI_BIT_PROTECT 1
`define FCI_STROBE_NS 80
`define FCI_STROBE_CYC (((`FCI_STROBE_NS) * 250 + 999) / 1000)
`define FCI_GAP_CYC 2
`endif

// [rtl/fci_pkg.sv]
// Purpose: Types for the flash command host controller.
// Assumes: Included constants file defines command codes.
// Notes: Operation codes are the user-side order codes.
package fci_pkg;
  typedef enum logic [3:0] {
    FCI_OP_READ_ARRAY = 4'h0,
    FCI_OP_READ_STATUS = 4'h1,
    FCI_OP_READ_ID = 4'h2,
    FCI_OP_QUERY = 4'h3,
    FCI_OP_CLEAR_STATUS = 4'h4,
    FCI_OP_WORD_PROG = 4'h5,
    FCI_OP_BYTE_PROG = 4'h6,
    FCI_OP_ERASE = 4'h7,
    FCI_OP_BUF_CONFIRM = 4'h8,
    FCI_OP_SUSPEND = 4'h9,
    FCI_OP_RESUME = 4'hA,
    FCI_OP_LOCK = 4'hB,
    FCI_OP_UNLOCK = 4'hC,
    FCI_OP_ECR = 4'hD,
    FCI_OP_OTP_PROG = 4'hE,
    FCI_OP_PIN_CFG = 4'hF
  } fci_op_t;
  typedef enum logic [2:0] {
    FCI_ST_IDLE = 3'b000,
    FCI_ST_WRITE = 3'b001,
    FCI_ST_GAP = 3'b011,
    FCI_ST_READ = 3'b010,
    FCI_ST_DONE = 3'b110
  } fci_state_t;
endpackage

// [dv/fci_flash_model.sv]
// Purpose: Behavioural flash device facing the host controller.
// Assumes: A write takes effect at the clock after the write strobe rises.
// Notes: Sequencer busy time is BUSY_CYC clocks; DEV_CODE is an arbitrary value.
`timescale 1ns/1ns
`default_nettype none
module fci_flash_model #(
  parameter int BUSY_CYC = 40,
  parameter logic [15:0] DEV_CODE = 16'h00A5
) (
  input wire logic clk_sys_i,
  input wire logic program_supply_enable_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic ce_n_i,
  output logic drive_o,
  output logic [15:0] dq_o
);
  logic [15:0] mem [0:255];
  logic [255:0] lock_blk;
  logic [15:0] pend, ecr_val, pin_val, otp_lock_word, last_cmd;
  logic [7:0] snap;
  logic [1:0] mode;
  logic we_q, program_fail_bit, supply_fault_bit, protect_fault_bit;
  int cnt, erase_cnt;
  wire logic [7:0] sr = {cnt == 0, 2'b00, program_fail_bit, supply_fault_bit, 1'b0,
                         protect_fault_bit, 1'b0};
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    {lock_blk, pend, mode, cnt, erase_cnt, snap, last_cmd} = '0;
    {program_fail_bit, supply_fault_bit, protect_fault_bit, we_q} = 4'h1;
    otp_lock_word = 16'hFFFE;
  end
  always @(negedge oe_n_i) snap <= sr;
  assign drive_o = !oe_n_i && !ce_n_i;
  always_comb begin
    case (mode)
      2'h0: dq_o = mem[addr_i[7:0]];
      2'h1: dq_o = {8'h00, snap};
      2'h2: dq_o = (addr_i == 24'h00_0001) ? DEV_CODE : 16'h0000;
      default: dq_o = (addr_i == 24'h00_0010) ? 16'h0051 : 16'h0000;
    endcase
  end
  always @(posedge clk_sys_i) begin
    we_q <= we_n_i;
    if (cnt > 0) cnt <= cnt - 1;
    if (we_n_i && !we_q) last_cmd <= dq_i;
    if (we_n_i && !we_q && pend == 16'h0000) begin
      case (dq_i)
        16'h00FF: mode <= 2'h0;
        16'h0070: mode <= 2'h1;
        16'h0090: mode <= 2'h2;
        16'h0098: mode <= 2'h3;
        16'h0050: {program_fail_bit, supply_fault_bit, protect_fault_bit} <= 3'h0;
        default: if (cnt == 0) begin
          pend <= dq_i;
          mode <= 2'h1;
        end
      endcase
    end else if (we_n_i && !we_q) begin
      pend <= 16'h0000;
      case (pend)
        16'h0040, 16'h0010: if (!supply_fault_bit) begin
          if (!program_supply_enable_i) {program_fail_bit, supply_fault_bit} <= 2'b11;
          else if (lock_blk[addr_i[23:16]]) {program_fail_bit, protect_fault_bit} <= 2'b11;
          else begin
            mem[addr_i[7:0]] <= mem[addr_i[7:0]] & dq_i;
            cnt <= BUSY_CYC;
          end
        end
        16'h0020: if (dq_i == 16'h00D0) begin
          if (lock_blk[addr_i[23:16]]) protect_fault_bit <= 1'b1;
          else begin
            foreach (mem[i]) mem[i] <= 16'hFFFF;
            erase_cnt <= erase_cnt + 1;
            cnt <= BUSY_CYC;
          end
        end
        16'h0060: case (dq_i)
          16'h0004: ecr_val <= addr_i[15:0];
          16'h0001: lock_blk[addr_i[23:16]] <= 1'b1;
          16'h00D0: lock_blk <= '0;
          default: ;
        endcase
        16'h00C0:
          if (addr_i < 24'h00_0080 || addr_i > 24'h00_0088) program_fail_bit <= 1'b1;
          else if (addr_i == 24'h00_0080) otp_lock_word <= otp_lock_word & dq_i;
          else if (addr_i > 24'h00_0084 && !otp_lock_word[1]) {program_fail_bit,
                                                               protect_fault_bit} <= 2'b11;
          else cnt <= BUSY_CYC;
        16'h00B8: pin_val <= dq_i;
        default: ;
      endcase
    end
  end
endmodule
`default_nettype wire

// [dv/fci_host_test.sv]
// Purpose: Self-checking bench for the flash command host controller.
// Assumes: The device model stands on the flash pins.
// Notes: Orders and reads are driven at rising edges by non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none
module fci_host_test import fci_pkg::*;;
  localparam logic [15:0] DEV_ID = 16'h00A5; // Arbitrary value.
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0;
  logic read_i = 1'b0;
  logic buf_start_i = 1'b0;
  logic supply_ok = 1'b1;
  logic [3:0] op_i = 4'h0;
  logic [23:0] addr_i = '0;
  logic [15:0] data_i = 16'h0000;
  logic [15:0] last_dq = 16'h0000;
  logic busy_o, done_o, seq_ready_o, err_flag_o, supply_block_o, flash_dq_oe_o, m_drive;
  logic flash_we_n_o, flash_oe_n_o, flash_ce_n_o;
  logic [15:0] rdata_o, flash_dq_o, flash_dq_i, m_dq;
  logic [23:0] flash_addr_o;
  int err_total = 0;
  int n_checks = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : (m_drive ? m_dq : ~last_dq);
  always @(posedge clk_sys_i) last_dq <= flash_dq_i;
  fci_host fci_host_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i),
    .addr_i(addr_i), .data_i(data_i), .buf_start_i(buf_start_i), .read_i(read_i),
    .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .seq_ready_o(seq_ready_o),
    .err_flag_o(err_flag_o), .supply_block_o(supply_block_o), .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(flash_dq_i),
    .flash_we_n_o(flash_we_n_o), .flash_oe_n_o(flash_oe_n_o), .flash_ce_n_o(flash_ce_n_o));
  fci_flash_model #(.BUSY_CYC(40), .DEV_CODE(DEV_ID)) fci_flash_model_i (
    .clk_sys_i(clk_sys_i), .program_supply_enable_i(supply_ok), .addr_i(flash_addr_o),
    .dq_i(flash_dq_i), .we_n_i(flash_we_n_o), .oe_n_i(flash_oe_n_o), .ce_n_i(flash_ce_n_o),
    .drive_o(m_drive), .dq_o(m_dq));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic xfer(input logic r, input logic [3:0] op, input logic [23:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_sys_i);
    op_i <= op;
    addr_i <= a;
    data_i <= d;
    read_i <= r;
    req_i <= !r;
    for (int i = 0; i < 80; i++) begin
      @(posedge clk_sys_i);
      if (done_o === 1'b1) break;
      req_i <= req_i && !busy_o;
      read_i <= read_i && !busy_o;
    end
    check("done", {15'h0000, done_o}, 16'h0001);
    q = rdata_o;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [23:0] a, input logic [15:0] d);
    logic [15:0] q;
    xfer(1'b0, op, a, d, q);
  endtask
  task automatic rchk(input logic [23:0] a, input logic [15:0] e, input string what);
    logic [15:0] q;
    xfer(1'b1, FCI_OP_READ_ARRAY, a, 16'h0000, q);
    check(what, q, e);
  endtask
  task automatic poll();
    logic [15:0] q;
    for (int i = 0; i < 20; i++) begin
      xfer(1'b1, FCI_OP_READ_ARRAY, '0, 16'h0000, q);
      if (q[7] === 1'b1) break;
    end
    check("ready", {15'h0000, seq_ready_o}, 16'h0001);
  endtask
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    cmd(FCI_OP_READ_STATUS, '0, 16'h0000);
    rchk('0, 16'h0080, "status idle");
    cmd(FCI_OP_WORD_PROG, 24'h00_0005, 16'h1234);
    rchk('0, 16'h0000, "status busy");
    poll();
    cmd(FCI_OP_READ_ARRAY, '0, 16'h0000);
    rchk(24'h00_0005, 16'h1234, "array word");
    cmd(FCI_OP_READ_ID, '0, 16'h0000);
    rchk(24'h00_0001, DEV_ID, "device code");
    cmd(FCI_OP_QUERY, '0, 16'h0000);
    rchk(24'h00_0010, 16'h0051, "query");
    cmd(FCI_OP_ECR, 24'h00_1234, 16'h0000);
    check("ecr", fci_flash_model_i.ecr_val, 16'h1234);
    cmd(FCI_OP_PIN_CFG, '0, 16'h0002);
    check("pin cfg", fci_flash_model_i.pin_val, 16'h0002);
    supply_ok <= 1'b0;
    cmd(FCI_OP_BYTE_PROG, 24'h00_0006, 16'h00AA);
    rchk('0, 16'h0098, "supply fault");
    check("block", {15'h0000, supply_block_o}, 16'h0001);
    supply_ok <= 1'b1;
    @(posedge clk_sys_i);
    op_i <= FCI_OP_WORD_PROG;
    req_i <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    check("refused", {15'h0000, busy_o}, 16'h0000);
    req_i <= 1'b0;
    cmd(FCI_OP_CLEAR_STATUS, '0, 16'h0000);
    rchk('0, 16'h0080, "cleared");
    check("err flag", {15'h0000, err_flag_o}, 16'h0000);
    cmd(FCI_OP_OTP_PROG, 24'h00_0090, 16'h1111);
    rchk('0, 16'h0090, "otp range");
    cmd(FCI_OP_OTP_PROG, 24'h00_0080, 16'hFFFD);
    cmd(FCI_OP_OTP_PROG, 24'h00_0086, 16'h2222);
    rchk('0, 16'h0092, "otp locked");
    cmd(FCI_OP_CLEAR_STATUS, '0, 16'h0000);
    buf_start_i <= 1'b1;
    cmd(FCI_OP_BUF_CONFIRM, '0, 16'h0000);
    check("buf setup", fci_flash_model_i.last_cmd, 16'h00E8);
    buf_start_i <= 1'b0;
    cmd(FCI_OP_BUF_CONFIRM, '0, 16'h0000);
    check("buf confirm", fci_flash_model_i.last_cmd, 16'h00D0);
    cmd(FCI_OP_SUSPEND, '0, 16'h0000);
    check("suspend", fci_flash_model_i.last_cmd, 16'h00B0);
    cmd(FCI_OP_RESUME, '0, 16'h0000);
    check("resume", fci_flash_model_i.last_cmd, 16'h00D0);
    cmd(FCI_OP_LOCK, 24'h01_0000, 16'h0000);
    cmd(FCI_OP_ERASE, 24'h01_0000, 16'h0000);
    rchk('0, 16'h0082, "erase locked");
    cmd(FCI_OP_CLEAR_STATUS, '0, 16'h0000);
    cmd(FCI_OP_UNLOCK, '0, 16'h0000);
    cmd(FCI_OP_ERASE, 24'h01_0000, 16'h0000);
    cmd(FCI_OP_ERASE, 24'h01_0000, 16'h0000);
    poll();
    check("erases", 16'(fci_flash_model_i.erase_cnt), 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
